// ===== src/rmcd_pkg.sv
package rmcd_pkg;
  // Command codes as they arrive in the first word of a command.
  localparam logic [7:0] CMD_REG_REL_VEL = 8'h00_E9;
  localparam logic [7:0] CMD_REG_REL_TIME = 8'h00_EB;
  localparam logic [7:0] CMD_ADD_TO_REG = 8'h00_F8;
  localparam logic [7:0] CMD_STATUS_CHECK = 8'h00_A4;
  // Number of consecutive registers read by a register move.
  localparam int MOVE_REG_COUNT = 3;
  // Bit of the polling status word set by the status check.
  localparam int POLL_FLAG_BIT = 6;
  // Reset value of the polling status word.
  localparam logic [15:0] POLL_RESET = 16'h0000;
  // Move kinds handed to the profile generator.
  typedef enum logic [0:0] {
    RMCD_MOVE_VEL = 1'b0,
    RMCD_MOVE_TIME = 1'b1
  } rmcd_move_t;
endpackage : rmcd_pkg

// ===== src/rmcd_reg_if.sv
`timescale 1ns/1ps
// Port of the user data register file.
interface rmcd_reg_if #(parameter int AW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [31:0] wdata;
  logic [AW-1:0] raddr;
  logic [31:0] rdata;
  modport master (output we, output waddr, output wdata, output raddr,
                  input rdata);
  modport slave (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : rmcd_reg_if

// ===== src/rmcd_regfile.sv
`timescale 1ns/1ps
// User data registers; read data come from a register one cycle later.
module rmcd_regfile #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  rmcd_reg_if.slave bus
);
  // Storage array, without reset to stay a plain memory.
  logic [31:0] mem [0:(1<<AW)-1];

  // Synchronous write port.
  always_ff @(posedge ref_clk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  // Registered read port.
  always_ff @(posedge ref_clk) begin
    bus.rdata <= mem[bus.raddr];
  end
endmodule : rmcd_regfile

// ===== src/rmcd_decoder.sv
`timescale 1ns/1ps
// Contract
// [R1] Time move reads distance, accel time, total time.
// [R2] Time move otherwise equals direct time move.
// [R3] Velocity move reads distance, accel, velocity.
// [R4] Four words: code, start reg, stops.
// [R5] Add operand into selected register, store sum.
// [R6] Operand is signed; negative decrements.
// [R7] Status check true sets poll bit six.
// [R8] Zero enable sets poll bit unconditionally.
// [R9] True when enabled bits match state bits.
module rmcd_decoder #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_arg0,
  input wire logic [31:0] cmd_arg1,
  input wire logic [15:0] cmd_arg2,
  input wire logic [15:0] internal_status,
  input wire logic poll_clear,
  input wire logic host_we,
  input wire logic [AW-1:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic cmd_ready,
  output logic move_start,
  output logic move_kind,
  output logic [31:0] move_distance,
  output logic [31:0] move_accel,
  output logic [31:0] move_third,
  output logic [15:0] move_stop_enable,
  output logic [15:0] move_stop_state,
  output logic [15:0] poll_status
);
  // Sequencer states.
  typedef enum logic [2:0] {
    RMCD_IDLE = 3'b000,
    RMCD_RD0 = 3'b001,
    RMCD_RD1 = 3'b010,
    RMCD_RD2 = 3'b011,
    RMCD_LAST = 3'b100,
    RMCD_ADD = 3'b101
  } rmcd_state_t;

  rmcd_state_t state;
  rmcd_state_t next_state;
  // Register file port.
  rmcd_reg_if #(.AW(AW)) rf ();
  // Latched command fields.
  logic [AW-1:0] base;
  logic [31:0] operand;
  logic [7:0] code;

  rmcd_regfile #(.AW(AW)) u_regs (
    .ref_clk(ref_clk),
    .bus(rf.slave)
  );

  // Condition evaluation used by the status check.
  function automatic logic rmcd_cond(input logic [15:0] en,
                                     input logic [15:0] st,
                                     input logic [15:0] isw);
    rmcd_cond = ((isw ^ st) & en) == 16'h0000; // [R9]
  endfunction : rmcd_cond

  // Next state: moves walk three reads, add walks one read.
  always_comb begin
    next_state = state;
    unique case (state)
      RMCD_IDLE: begin
        if (cmd_valid && (cmd_code == rmcd_pkg::CMD_REG_REL_TIME ||
            cmd_code == rmcd_pkg::CMD_REG_REL_VEL)) begin
          next_state = RMCD_RD0;
        end else if (cmd_valid && cmd_code == rmcd_pkg::CMD_ADD_TO_REG) begin
          next_state = RMCD_ADD;
        end
      end
      RMCD_RD0: next_state = RMCD_RD1;
      RMCD_RD1: next_state = RMCD_RD2;
      RMCD_RD2: next_state = RMCD_LAST;
      RMCD_LAST: next_state = RMCD_IDLE;
      RMCD_ADD: next_state = RMCD_LAST;
      default: next_state = RMCD_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RMCD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready is held low while a multi-cycle command is busy.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (next_state == RMCD_IDLE);
    end
  end

  // Capture the command words when it is accepted.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base <= '0;
      operand <= 32'h0000_0000;
      code <= 8'h00;
      move_stop_enable <= 16'h0000;
      move_stop_state <= 16'h0000;
    end else if (state == RMCD_IDLE && cmd_valid && cmd_ready) begin
      // Starting register is unsigned; low bits index the file.
      base <= cmd_arg0[AW-1:0]; // [R4]
      operand <= cmd_arg1;
      code <= cmd_code;
      move_stop_enable <= cmd_arg1[15:0]; // [R4]
      move_stop_state <= cmd_arg2; // [R4]
    end
  end

  // Register file addressing; reads run N, N+1, N+2 back to back.
  always_comb begin
    rf.raddr = base;
    unique case (state)
      RMCD_RD1: rf.raddr = AW'(base + 1); // [R1] [R3]
      RMCD_RD2: rf.raddr = AW'(base + 2); // [R1] [R3]
      default: rf.raddr = base;
    endcase
  end

  // Signed add: the sum wraps modulo 2**32, so negatives subtract.
  // Host preload writes share the port, but only while the sequencer is
  // idle, so they can never collide with the write-back of an add.
  always_comb begin
    rf.we = (state == RMCD_LAST) && (code == rmcd_pkg::CMD_ADD_TO_REG); // [R5]
    rf.waddr = base;
    rf.wdata = 32'($signed(rf.rdata) + $signed(operand)); // [R5] [R6]
    if (state == RMCD_IDLE && host_we) begin
      rf.we = 1'b1;
      rf.waddr = host_addr;
      rf.wdata = host_wdata;
    end
  end

  // Collect move parameters as the read data arrive.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_distance <= 32'h0000_0000;
      move_accel <= 32'h0000_0000;
      move_third <= 32'h0000_0000;
    end else begin
      if (state == RMCD_RD1) move_distance <= rf.rdata; // [R1] [R3]
      if (state == RMCD_RD2) move_accel <= rf.rdata; // [R1] [R3]
      if (state == RMCD_LAST && code != rmcd_pkg::CMD_ADD_TO_REG) begin
        move_third <= rf.rdata; // [R1] [R3]
      end
    end
  end

  // Start pulse uses the same outputs as a direct relative move.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_start <= 1'b0;
      move_kind <= rmcd_pkg::RMCD_MOVE_VEL;
    end else begin
      move_start <= (state == RMCD_LAST) &&
                    (code != rmcd_pkg::CMD_ADD_TO_REG); // [R2]
      if (state == RMCD_LAST) begin
        move_kind <= (code == rmcd_pkg::CMD_REG_REL_TIME) ?
                     rmcd_pkg::RMCD_MOVE_TIME : rmcd_pkg::RMCD_MOVE_VEL; // [R2]
      end
    end
  end

  // Poll flag: a set in the same cycle as a host clear wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_status <= rmcd_pkg::POLL_RESET;
    end else if (state == RMCD_IDLE && cmd_valid && cmd_ready &&
                 cmd_code == rmcd_pkg::CMD_STATUS_CHECK &&
                 (cmd_arg0 == 16'h0000 || // [R8]
                  rmcd_cond(cmd_arg0, cmd_arg2, internal_status))) begin
      poll_status[rmcd_pkg::POLL_FLAG_BIT] <= 1'b1; // [R7]
    end else if (poll_clear) begin
      poll_status[rmcd_pkg::POLL_FLAG_BIT] <= 1'b0;
    end
  end

endmodule : rmcd_decoder

// ===== verif/rmcd_decoder_props.sv
`timescale 1ns/1ps
// Ties each answer of the decoder to the command that caused it.
module rmcd_decoder_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_arg0,
  input wire logic [31:0] cmd_arg1,
  input wire logic [15:0] cmd_arg2,
  input wire logic [15:0] internal_status,
  input wire logic cmd_ready,
  input wire logic move_start,
  input wire logic move_kind,
  input wire logic [15:0] move_stop_enable,
  input wire logic [15:0] move_stop_state,
  input wire logic [15:0] poll_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Take strobes: any command, time move, velocity move, status check.
  logic tk, tt, tv, tc;
  assign tk = cmd_valid && cmd_ready;
  assign tt = tk && cmd_code == rmcd_pkg::CMD_REG_REL_TIME;
  assign tv = tk && cmd_code == rmcd_pkg::CMD_REG_REL_VEL;
  assign tc = tk && cmd_code == rmcd_pkg::CMD_STATUS_CHECK;
  a_move_start_lat: assert property ((tt || tv) |-> ##5 move_start)
    else $error("Move start late");
  a_time_kind: assert property (tt |-> ##5 move_kind)
    else $error("Time move kind wrong");
  a_vel_kind: assert property (tv |-> ##5 !move_kind)
    else $error("Velocity move kind wrong");
  a_stop_copy: assert property ((tt || tv) |-> ##5
    move_stop_enable == $past(cmd_arg1[15:0], 5) &&
    move_stop_state == $past(cmd_arg2, 5)) else $error("Stop words wrong");
  a_busy_move: assert property ((tt || tv) |=> !cmd_ready [*3])
    else $error("Ready during move");
  a_zero_enable: assert property (tc && cmd_arg0 == 16'h0000
    |-> ##2 poll_status[6]) else $error("Poll flag not set");
  a_cond_true: assert property (tc && ((internal_status ^ cmd_arg2)
    & cmd_arg0) == 16'h0000 |-> ##2 poll_status[6]) else $error("No flag");
  a_no_false_set: assert property ($rose(poll_status[6])
    |-> $past(tc) || $past(tc, 2)) else $error("Poll flag from nowhere");
  a_pulse_once: assert property (move_start |=> !move_start)
    else $error("Move start too long");
  cover property (tt);
  cover property (tv);
  cover property (tc && cmd_arg0 == 16'h0000);
endmodule : rmcd_decoder_props

bind rmcd_decoder rmcd_decoder_props u_props (.*);

// ===== verif/rmcd_host_model.sv
`timescale 1ns/1ps
// Host side: offers one command and holds it until it is taken or 16 clocks pass.
module rmcd_host_model (
  input wire logic ref_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_arg0,
  output logic [31:0] cmd_arg1,
  output logic [15:0] cmd_arg2
);
  initial begin
    cmd_valid = 1'h0;
    {cmd_code, cmd_arg0, cmd_arg1, cmd_arg2} = '0;
  end
  // Sends all four words at once; ok stays low if never taken.
  task automatic send(input logic [71:0] w, output bit ok);
    int n;
    @(negedge ref_clk);
    {cmd_code, cmd_arg0, cmd_arg1, cmd_arg2} = w;
    cmd_valid = 1'h1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk);
      ok = cmd_ready === 1'h1;
    end
    @(negedge ref_clk);
    // Released words flip so stale data never looks still valid.
    cmd_valid = 1'h0;
    {cmd_code, cmd_arg0, cmd_arg1, cmd_arg2} = ~w;
  endtask : send
endmodule : rmcd_host_model

// ===== verif/test_register_motion_command_decoder.sv
`timescale 1ns/1ps
// Random commands of every code; move and status check answers checked at the ports, adds only in the model.
module test_register_motion_command_decoder;
  logic ref_clk, rst_n, poll_clear, cmd_valid, cmd_ready;
  logic move_start, move_kind;
  logic [7:0] cmd_code;
  logic [15:0] cmd_arg0, cmd_arg2, internal_status, poll_status;
  logic [15:0] move_stop_enable, move_stop_state;
  logic [31:0] cmd_arg1;
  logic host_we;
  logic [7:0] host_addr;
  logic [31:0] host_wdata;
  logic [31:0] move_distance, move_accel, move_third;
  // Bench copy of the register file, kept by preload and adds.
  logic [31:0] model [256];
  int errors, compares;
  rmcd_decoder dut_u (.*);
  rmcd_host_model host_u (.*);
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Condition holds when every enabled bit matches the state.
  function automatic bit exp_hit(logic [15:0] en, st, isw);
    return ((isw ^ st) & en) == 16'h0000;
  endfunction : exp_hit
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    logic [7:0] codes [5];
    logic [71:0] w;
    logic [15:0] en, st;
    bit ok;
    int n;
    logic [7:0] b;
    codes = '{rmcd_pkg::CMD_REG_REL_VEL, rmcd_pkg::CMD_REG_REL_TIME,
      rmcd_pkg::CMD_ADD_TO_REG, rmcd_pkg::CMD_STATUS_CHECK, 8'h01};
    {errors, compares, rst_n, poll_clear, internal_status} = '0;
    {host_we, host_addr, host_wdata} = '0;
    void'($urandom(95444));
    repeat (16) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    // Preload every register with a random word while idle.
    for (int a = 0; a < 256; a++) begin
      host_we = 1'h1;
      host_addr = 8'(a);
      host_wdata = $urandom;
      model[a] = host_wdata;
      @(negedge ref_clk);
    end
    host_we = 1'h0;
    @(negedge ref_clk);
    for (int i = 0; i < 40; i++) begin
      internal_status = 16'($urandom);
      en = (i % 4 == 0) ? 16'h0000 : 16'($urandom);
      st = (i % 3 == 0) ? internal_status : 16'($urandom);
      w = {codes[i % 5], en, 32'($urandom), st};
      b = w[55:48];
      poll_clear = 1'h1;
      @(negedge ref_clk);
      poll_clear = 1'h0;
      chk(poll_status[6], 1'h0);
      host_u.send(w, ok);
      if (!ok) begin
        errors++;
        close_out();
      end
      if (w[71:64] == rmcd_pkg::CMD_STATUS_CHECK) begin
        @(negedge ref_clk);
        chk(poll_status[6], exp_hit(en, st, internal_status));
      end else if (w[71:64] == codes[0] || w[71:64] == codes[1]) begin
        for (n = 1; n < 9 && move_start !== 1'h1; n++) @(negedge ref_clk);
        chk(n, 5);
        chk(move_kind, w[71:64] == codes[1]);
        chk(move_stop_enable, w[31:16]);
        chk(move_stop_state, w[15:0]);
        chk(move_distance, model[b]);
        chk(move_accel, model[8'(b + 8'h01)]);
        chk(move_third, model[8'(b + 8'h02)]);
      end else begin
        if (w[71:64] == rmcd_pkg::CMD_ADD_TO_REG) begin
          model[b] = model[b] + w[47:16];
        end
        repeat (3) @(negedge ref_clk);
      end
    end
    close_out();
  end
endmodule : test_register_motion_command_decoder
